// ---- rx_cfg_consts.svh ----
`ifndef RX_CFG_CONSTS_SVH
`define RX_CFG_CONSTS_SVH

// Register indices, equal to the select bits of each word
`define IDX_CORR     4'h6
`define IDX_RBSET    4'h7
`define IDX_PDTEST   4'h8
`define IDX_AGC      4'h9
`define IDX_AGC2     4'hA
`define IDX_TEST     4'hC
`define IDX_OFFS     4'hD
`define IDX_CTRL     4'hE
`define IDX_STAT     4'hF

// Field positions
`define CAL_BIT       19
`define LNA_MODE_BIT  15
`define DBW_LSB       20
`define RB_SEL_LSB    4
`define RB_EN_BIT     8
`define PD_LOGAMP_BIT 10
`define MATCH_BIT     12
`define AGC_LOW_LSB   4
`define AGC_HIGH_LSB  11
`define AGC_EN_BIT    18
`define LNA_GAIN_LSB  19
`define TMODE_LSB     14
`define OFFS_LSB      4
`define GAIN_LSB      17
`define DEMOD_DIV_LSB 0
`define CDR_DIV_LSB   8

// Reset values
`define AGC_RST  32'h000631E9
`define CTRL_RST 32'h0000080E

// Codes and limits
`define TM_DAC_RAW  4'h7
`define TM_DAC_OFFS 4'hA
`define LNA_TOP     2'h3
`define SD_FS       20'h07FFF

`endif

// ---- rx_cfg_pkg.sv ----
package rx_cfg_pkg;

    typedef enum logic [1:0]
    {
        RB_RSSI,
        RB_BATTERY,
        RB_TEMP,
        RB_ADCIN
    } rb_sel_t;

    typedef logic [31:0] cfg_word_t;

endpackage : rx_cfg_pkg

// ---- rx_config_test_dac.sv ----
// Overview of operation
// R1: Software sets filter divider for 50 kHz
// R2: Calibration starts on every trigger-high write
// R3: Software calibrates only after crystal settles
// R4: Software keeps discriminator bandwidth at most 600
// R5: Reduced LNA mode blocks top gain step
// R6: RSSI readback only in receive mode
// R7: Transmit ADC readback needs log-amp powered
// R8: Matching select bit resets to zero
// R9: Gain limits default 30 and 70
// R10: Software keeps gain limits over 30 apart
// R11: Gain 30 only with normal LNA mode
// R12: Software writes zeros to AGC2 upper bits
// R13: Sixteen-bit input to second-order bit stream
// R14: DAC uses recovery clock; fast clock stops recovery
// R15: Mode 7 raw, mode 10 offset-removed
// R16: DAC input from active demodulator
// R17: DAC input is scaled signal, offset removed in mode 10 only
// R18: Software programs half the frequency error
// R19: Serial word routed by low select bits
// R20: DAC output updates per tick, idle zero
`timescale 1ns/1ps
`include "rx_cfg_consts.svh"
module rx_config_test_dac
    import rx_cfg_pkg::*;
(
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        reset,
    // Avalon-MM slave
    input  wire logic [3:0]  address,
    input  wire logic        read,
    input  wire logic        write,
    input  wire logic [31:0] writedata,
    output logic      [31:0] readdata,
    output logic             waitrequest,
    // Serial write port
    input  wire logic        serial_clock_pin,
    input  wire logic        serial_data_pin,
    input  wire logic        load_strobe,
    // Receiver state
    input  wire logic        tx_mode,
    input  wire logic        corr_demod_sel,
    input  wire logic [1:0]  agc_lna_request,
    input  wire logic [15:0] corr_filter_out,
    input  wire logic [15:0] lin_filter_out,
    // Configuration outputs
    output logic             filter_cal_start,
    output logic [1:0]       lna_gain_sel,
    output logic             readback_valid,
    output logic             logamp_powerdown,
    output logic             lna_pa_match_sel,
    output logic [6:0]       gain_low_limit,
    output logic [6:0]       gain_high_limit,
    output logic [9:0]       discrim_bandwidth,
    // Clock enables and test DAC
    output logic             demodulator_clock,
    output logic             recovery_clock,
    output logic             recovery_active,
    output logic             clock_output_pin
);

    cfg_word_t          cfg_r [16];
    logic               ack_r;
    logic               av_wr;
    logic               ser_wr;
    logic [3:0]         ser_idx;
    logic [7:0]         demod_cnt_r;
    logic [7:0]         cdr_cnt_r;
    logic [7:0]         demod_div;
    logic [7:0]         cdr_div;
    logic [3:0]         test_mode;
    logic               dac_on;
    logic [15:0]        dac_in_r;
    logic [1:0]         lna_nxt;
    logic               rb_valid_nxt;
    rb_sel_t            rb_sel;
    logic               agc_en;
    logic               rx_mode;
    word_if             ser ();

    function automatic logic writable(input logic [3:0] idx);
        writable = (idx >= `IDX_CORR) && (idx <= `IDX_CTRL) && (idx != 4'hB);
    endfunction : writable

    function automatic cfg_word_t reset_value(input logic [3:0] idx);
        case (idx)
            `IDX_AGC:  reset_value = `AGC_RST;
            `IDX_CTRL: reset_value = `CTRL_RST;
            default:   reset_value = {28'h0, idx};
        endcase
    endfunction : reset_value

    function automatic logic [1:0] clamp_lna(input logic [1:0] g, input logic reduced);
        clamp_lna = (reduced && (g == `LNA_TOP)) ? 2'h2 : g;
    endfunction : clamp_lna

    function automatic logic [15:0] scale(input logic [15:0] sig,
                                          input logic [12:0] offs,
                                          input logic [2:0]  gain);
        logic signed [17:0] diff;
        logic signed [24:0] wide;
        diff = signed'({{2{sig[15]}}, sig}) - signed'({5'h0, offs});
        wide = 25'(signed'({{7{diff[17]}}, diff}) <<< gain);
        if (wide > 25'sh0007FFF)
            scale = 16'h7FFF;
        else if (wide < -25'sh0007FFF)
            scale = 16'h8001;
        else
            scale = wide[15:0];
    endfunction : scale

    serial_word_in u_serial
    (
        .clk              (clk),
        .reset            (reset),
        .serial_clock_pin (serial_clock_pin),
        .serial_data_pin  (serial_data_pin),
        .load_strobe      (load_strobe),
        .out              (ser.src)
    );

    // R19: select-bit routing
    assign ser_idx = ser.word[3:0];
    assign ser_wr  = ser.valid && writable(ser_idx);

    // Bus answer one cycle after request, stalled by a serial word
    assign waitrequest = (read || write) && !ack_r;
    assign av_wr       = write && ack_r && writable(address);

    always_ff @(posedge clk)
    begin
        if (reset)
            ack_r <= 1'b0;
        else
            ack_r <= (read || write) && !ack_r && !ser.valid;
    end

    // R8: register file with reset defaults
    // R9: gain limit defaults
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            for (int i = 0; i < 16; i++)
                cfg_r[i] <= reset_value(4'(i));
        end
        else
        begin
            // R19: serial word takes its register
            if (ser_wr)
                cfg_r[ser_idx] <= ser.word;
            if (av_wr && !(ser_wr && (ser_idx == address)))
                cfg_r[address] <= writedata;
        end
    end

    always_ff @(posedge clk)
    begin
        if (reset)
            readdata <= 32'h0;
        else if (read && !ack_r)
        begin
            if (address == `IDX_STAT)
                readdata <= {26'h0, dac_on, recovery_active, lna_gain_sel,
                             readback_valid, filter_cal_start};
            else if (writable(address))
                readdata <= cfg_r[address];
            else
                readdata <= 32'h0;
        end
    end

    // R2: calibration start pulse
    always_ff @(posedge clk)
    begin
        if (reset)
            filter_cal_start <= 1'b0;
        else
            filter_cal_start <= (ser_wr && (ser_idx == `IDX_CORR) && ser.word[`CAL_BIT])
                || (av_wr && (address == `IDX_CORR) && writedata[`CAL_BIT]);
    end

    assign agc_en  = cfg_r[`IDX_AGC][`AGC_EN_BIT];
    assign rx_mode = !tx_mode;
    assign rb_sel  = rb_sel_t'(cfg_r[`IDX_RBSET][`RB_SEL_LSB +: 2]);

    // R5: reduced mode caps AGC choice
    // R11: gain 30 only in normal mode
    always_comb
    begin
        lna_nxt = clamp_lna(agc_en ? agc_lna_request
                                   : cfg_r[`IDX_AGC][`LNA_GAIN_LSB +: 2],
                            cfg_r[`IDX_CORR][`LNA_MODE_BIT]);
    end

    // R6: readback validity by mode
    // R7: transmit ADC needs log-amp
    always_comb
    begin
        rb_valid_nxt = 1'b0;
        if (cfg_r[`IDX_RBSET][`RB_EN_BIT])
        begin
            case (rb_sel)
                RB_RSSI: rb_valid_nxt = rx_mode;
                default:
                begin
                    if (tx_mode)
                        rb_valid_nxt = !cfg_r[`IDX_PDTEST][`PD_LOGAMP_BIT];
                    else
                        rb_valid_nxt = !agc_en;
                end
            endcase
        end
    end

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            lna_gain_sel   <= 2'h0;
            readback_valid <= 1'b0;
        end
        else
        begin
            lna_gain_sel   <= lna_nxt;
            readback_valid <= rb_valid_nxt;
        end
    end

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            logamp_powerdown  <= 1'b0;
            lna_pa_match_sel  <= 1'b0;
            gain_low_limit    <= 7'h0;
            gain_high_limit   <= 7'h0;
            discrim_bandwidth <= 10'h0;
        end
        else
        begin
            logamp_powerdown  <= cfg_r[`IDX_PDTEST][`PD_LOGAMP_BIT];
            lna_pa_match_sel  <= cfg_r[`IDX_PDTEST][`MATCH_BIT];
            gain_low_limit    <= cfg_r[`IDX_AGC][`AGC_LOW_LSB +: 7];
            gain_high_limit   <= cfg_r[`IDX_AGC][`AGC_HIGH_LSB +: 7];
            discrim_bandwidth <= cfg_r[`IDX_CORR][`DBW_LSB +: 10];
        end
    end

    // R14: demodulator and recovery clock enables
    assign demod_div = cfg_r[`IDX_CTRL][`DEMOD_DIV_LSB +: 8];
    assign cdr_div   = cfg_r[`IDX_CTRL][`CDR_DIV_LSB +: 8];

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            demod_cnt_r       <= 8'h0;
            demodulator_clock <= 1'b0;
        end
        else if (demod_cnt_r + 8'h1 >= demod_div)
        begin
            demod_cnt_r       <= 8'h0;
            demodulator_clock <= 1'b1;
        end
        else
        begin
            demod_cnt_r       <= demod_cnt_r + 8'h1;
            demodulator_clock <= 1'b0;
        end
    end

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            cdr_cnt_r      <= 8'h0;
            recovery_clock <= 1'b0;
        end
        else if (demodulator_clock)
        begin
            if (cdr_cnt_r + 8'h1 >= cdr_div)
            begin
                cdr_cnt_r      <= 8'h0;
                recovery_clock <= 1'b1;
            end
            else
            begin
                cdr_cnt_r      <= cdr_cnt_r + 8'h1;
                recovery_clock <= 1'b0;
            end
        end
        else
            recovery_clock <= 1'b0;
    end

    // R14: recovery halts at demodulator rate
    always_ff @(posedge clk)
    begin
        if (reset)
            recovery_active <= 1'b0;
        else
            recovery_active <= cdr_div > 8'h1;
    end

    // R15: test mode decode
    assign test_mode = cfg_r[`IDX_TEST][`TMODE_LSB +: 4];
    assign dac_on    = (test_mode == `TM_DAC_RAW) || (test_mode == `TM_DAC_OFFS);

    // R16: active demodulator source
    // R17: offset removal and gain
    always_ff @(posedge clk)
    begin
        if (reset)
            dac_in_r <= 16'h0;
        else
            dac_in_r <= scale(corr_demod_sel ? corr_filter_out : lin_filter_out,
                              (test_mode == `TM_DAC_OFFS)
                                  ? cfg_r[`IDX_OFFS][`OFFS_LSB +: 13] : 13'h0,
                              cfg_r[`IDX_OFFS][`GAIN_LSB +: 3]);
    end

    // R13: second-order modulator
    // R20: per recovery tick, idle zero
    sigma_delta2 u_dac
    (
        .clk     (clk),
        .reset   (reset),
        .tick    (recovery_clock),
        .enable  (dac_on),
        .din     (dac_in_r),
        .bit_out (clock_output_pin)
    );

endmodule : rx_config_test_dac

// ---- rx_config_test_dac_props.sv ----
`timescale 1ns/1ps
module rx_cfg_props
(
    // Clock and reset
    input wire logic        clk,
    input wire logic        reset,
    // Bus
    input wire logic [3:0]  address,
    input wire logic        read,
    input wire logic        write,
    input wire logic [31:0] writedata,
    input wire logic [31:0] readdata,
    input wire logic        waitrequest,
    // Outputs
    input wire logic        filter_cal_start,
    input wire logic [1:0]  lna_gain_sel,
    input wire logic        logamp_powerdown,
    input wire logic        lna_pa_match_sel,
    input wire logic [6:0]  gain_low_limit,
    input wire logic [6:0]  gain_high_limit,
    input wire logic        clock_output_pin
);
    logic       reduced_r;
    logic       dac_on_r;
    logic [1:0] off_cnt_r;
    logic [1:0] pd_r;
    wire        wr_ok = write && !waitrequest;
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    // Shadow of bus-written fields
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            reduced_r <= 1'b0;
            dac_on_r  <= 1'b0;
            pd_r      <= 2'h0;
        end
        else if (wr_ok)
        begin
            if (address == 4'h6)
                reduced_r <= writedata[15];
            if (address == 4'hC)
                dac_on_r <= (writedata[17:14] == 4'h7) || (writedata[17:14] == 4'hA);
            if (address == 4'h8)
                pd_r <= {writedata[12], writedata[10]};
        end
    end
    // Cycles since the test mode was turned off
    always_ff @(posedge clk)
    begin
        if (reset || dac_on_r)
            off_cnt_r <= 2'h0;
        else if (off_cnt_r != 2'h3)
            off_cnt_r <= off_cnt_r + 2'h1;
    end
    a_cal_one_cycle: assert property (filter_cal_start |=> !filter_cal_start)
        else $error("calibration pulse longer than one cycle");
    a_cal_on_write: assert property (wr_ok && address == 4'h6 && writedata[19]
        |-> ##[1:2] filter_cal_start) else $error("calibration did not start");
    a_lna_top_blocked: assert property (reduced_r && $past(reduced_r)
        |-> lna_gain_sel != 2'h3) else $error("top gain step in reduced mode");
    a_dac_idle_zero: assert property (off_cnt_r == 2'h3 |-> !clock_output_pin)
        else $error("bit stream active with test mode off");
    a_bus_answer: assert property ((read || write) |-> ##[0:4] !waitrequest)
        else $error("bus request not answered");
    a_unmapped_zero: assert property (read && !waitrequest && address < 4'h6
        |-> readdata == 32'h0) else $error("unmapped read not zero");
    a_limit_defaults: assert property ($fell(reset) |-> ##[0:2]
        (gain_low_limit == 7'h1E && gain_high_limit == 7'h46)) else $error("bad limits");
    a_pd_copy: assert property (pd_r == $past(pd_r)
        |-> {lna_pa_match_sel, logamp_powerdown} == pd_r) else $error("power-down copy wrong");
endmodule : rx_cfg_props

// ---- rx_config_test_dac_tb.sv ----
`timescale 1ns/1ps
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin mismatches++; \
    $display("FAIL %0t value mismatch", $time); end end
module rx_config_test_dac_tb;
    import rx_cfg_pkg::*;
    logic        clk, reset, read, write, waitrequest, tx_mode, corr_demod_sel;
    logic        serial_clock_pin, serial_data_pin, load_strobe, filter_cal_start;
    logic        readback_valid, logamp_powerdown, lna_pa_match_sel, demodulator_clock;
    logic        recovery_clock, recovery_active, clock_output_pin;
    logic [3:0]  address;
    logic [31:0] writedata, readdata, q;
    logic [1:0]  agc_lna_request, lna_gain_sel;
    logic [15:0] corr_filter_out, lin_filter_out;
    logic [6:0]  gain_low_limit, gain_high_limit;
    logic [9:0]  discrim_bandwidth;
    int          mismatches, compares, cal_cnt, ones, dem_cnt, rec_cnt;
    rx_config_test_dac i_rx_config_test_dac (.clk, .reset, .address, .read, .write,
        .writedata, .readdata, .waitrequest, .serial_clock_pin, .serial_data_pin,
        .load_strobe, .tx_mode, .corr_demod_sel, .agc_lna_request, .corr_filter_out,
        .lin_filter_out, .filter_cal_start, .lna_gain_sel, .readback_valid, .logamp_powerdown,
        .lna_pa_match_sel, .gain_low_limit, .gain_high_limit, .discrim_bandwidth,
        .demodulator_clock, .recovery_clock, .recovery_active, .clock_output_pin);
    initial
    begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    always @(negedge clk)
    begin
        if (filter_cal_start === 1'b1) cal_cnt++;
        if (clock_output_pin === 1'b1) ones++;
        if (demodulator_clock === 1'b1) dem_cnt++;
        if (recovery_clock === 1'b1) rec_cnt++;
    end
    task automatic end_of_test;
        $display("Counts: %0d compares, %0d mismatches", compares, mismatches);
        if (mismatches == 0 && compares > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : end_of_test
    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        read <= !wr;
        write <= wr;
        address <= a;
        writedata <= d;
        @(posedge clk);
        while (waitrequest !== 1'b0 && n < 20)
        begin
            n++;
            @(posedge clk);
        end
        q = readdata;
        read <= 1'b0;
        write <= 1'b0;
        if (n == 20)
        begin
            mismatches++;
            end_of_test();
        end
    endtask : bus
    task automatic ser(input logic [31:0] w);
        for (int i = 31; i >= 0; i--)
        begin
            serial_data_pin <= w[i];
            repeat (6) @(posedge clk);
            serial_clock_pin <= 1'b1;
            repeat (6) @(posedge clk);
            serial_clock_pin <= 1'b0;
        end
        repeat (6) @(posedge clk);
        load_strobe <= 1'b1;
        repeat (6) @(posedge clk);
        load_strobe <= 1'b0;
        repeat (8) @(posedge clk);
    endtask : ser
    task automatic t_reset;
        bus(1'b0, 4'h9, 32'h0);
        `CHK(q, 32'h000631E9);
        `CHK(gain_low_limit, 7'h1E);
        `CHK(gain_high_limit, 7'h46);
        `CHK(recovery_active, 1'b1);
        dem_cnt = 0;
        rec_cnt = 0;
        repeat (112) @(posedge clk);
        `CHK(dem_cnt, 8);
        `CHK(rec_cnt, 1);
        bus(1'b0, 4'h8, 32'h0);
        `CHK(q[12], 1'b0);
        `CHK(lna_pa_match_sel, 1'b0);
        bus(1'b0, 4'h2, 32'hFFFFFFFF);
        `CHK(q, 32'h0);
        bus(1'b1, 4'hA, 32'h0000ABCA);
        bus(1'b0, 4'hA, 32'h0);
        `CHK(q, 32'h0000ABCA);
        bus(1'b1, 4'h9, 32'h000678F9);
        repeat (3) @(posedge clk);
        `CHK(gain_low_limit, 7'h0F);
        `CHK(gain_high_limit, 7'h4F);
        $display("reset test done");
    endtask : t_reset
    task automatic t_cal;
        int c;
        c = cal_cnt;
        bus(1'b1, 4'h6, 32'h00080006);
        bus(1'b1, 4'h6, 32'h00080006);
        repeat (3) @(posedge clk);
        `CHK(cal_cnt, c + 2);
        ser(32'h25880006);
        `CHK(cal_cnt, c + 3);
        `CHK(discrim_bandwidth, 10'h258);
        ser(32'h3FF00003);
        `CHK(discrim_bandwidth, 10'h258);
        $display("calibration test done");
    endtask : t_cal
    task automatic t_lna;
        bus(1'b1, 4'h6, 32'h00008006);
        repeat (3) @(posedge clk);
        `CHK(lna_gain_sel, 2'h2);
        bus(1'b0, 4'hF, 32'h0);
        `CHK(q[3:2], 2'h2);
        bus(1'b1, 4'h6, 32'h00000006);
        repeat (3) @(posedge clk);
        `CHK(lna_gain_sel, 2'h3);
        $display("lna test done");
    endtask : t_lna
    task automatic t_rb;
        bus(1'b1, 4'h7, 32'h00000107);
        repeat (3) @(posedge clk);
        `CHK(readback_valid, 1'b1);
        tx_mode <= 1'b1;
        repeat (3) @(posedge clk);
        `CHK(readback_valid, 1'b0);
        bus(1'b1, 4'h7, 32'h00000117);
        repeat (3) @(posedge clk);
        `CHK(readback_valid, 1'b1);
        tx_mode <= 1'b0;
        repeat (3) @(posedge clk);
        `CHK(readback_valid, 1'b0);
        tx_mode <= 1'b1;
        bus(1'b1, 4'h8, 32'h00000408);
        repeat (3) @(posedge clk);
        `CHK(readback_valid, 1'b0);
        `CHK(logamp_powerdown, 1'b1);
        bus(1'b1, 4'h8, 32'h00000008);
        tx_mode <= 1'b0;
        $display("readback test done");
    endtask : t_rb
    task automatic dens(input logic [31:0] t12, input logic [31:0] t13, input logic sel,
                        input logic [15:0] l, input int lo, input int hi);
        bus(1'b1, 4'hC, t12);
        bus(1'b1, 4'hD, t13);
        corr_demod_sel <= sel;
        lin_filter_out <= l;
        repeat (32) @(posedge clk);
        ones = 0;
        repeat (256) @(posedge clk);
        `CHK(ones >= lo && ones <= hi, 1'b1);
    endtask : dens
    task automatic t_dac;
        bus(1'b1, 4'hE, 32'h00000101);
        repeat (3) @(posedge clk);
        `CHK(recovery_active, 1'b0);
        ones = 0;
        repeat (256) @(posedge clk);
        `CHK(ones, 0);
        dens(32'h0001C00C, 32'h0000000D, 1'b1, 16'h8000, 248, 256);
        dens(32'h0001C00C, 32'h0000000D, 1'b0, 16'h8000, 0, 8);
        dens(32'h0002800C, 32'h0001000D, 1'b0, 16'h1000, 120, 136);
        dens(32'h0002800C, 32'h0005000D, 1'b0, 16'h2000, 184, 200);
        dens(32'h0001C00C, 32'h0001000D, 1'b0, 16'h2000, 152, 168);
        bus(1'b1, 4'hC, 32'h0000000C);
        repeat (8) @(posedge clk);
        ones = 0;
        repeat (256) @(posedge clk);
        `CHK(ones, 0);
        $display("dac test done");
    endtask : t_dac
    initial
    begin
        reset = 1'b1;
        {read, write, serial_clock_pin, serial_data_pin, load_strobe} = 5'h0;
        {tx_mode, corr_demod_sel, address, writedata} = 38'h0;
        agc_lna_request = 2'h3;
        corr_filter_out = 16'h7FFF;
        lin_filter_out = 16'h8000;
        repeat (4) @(posedge clk);
        reset <= 1'b0;
        t_reset();
        t_cal();
        t_lna();
        t_rb();
        t_dac();
        end_of_test();
    end
endmodule : rx_config_test_dac_tb
bind rx_config_test_dac rx_cfg_props i_rx_cfg_props (.clk, .reset, .address, .read, .write,
    .writedata, .readdata, .waitrequest, .filter_cal_start, .lna_gain_sel, .logamp_powerdown,
    .lna_pa_match_sel, .gain_low_limit, .gain_high_limit, .clock_output_pin);

// ---- serial_word_in.sv ----
`timescale 1ns/1ps
module serial_word_in
    import rx_cfg_pkg::*;
(
    // Clock and reset
    input  wire logic clk,
    input  wire logic reset,
    // Pins
    input  wire logic serial_clock_pin,
    input  wire logic serial_data_pin,
    input  wire logic load_strobe,
    // Latched word
    word_if.src       out
);

    logic [2:0] sync1_r;
    logic [2:0] sync2_r;
    logic [2:0] sync3_r;
    logic [2:0] filt_r;
    logic [2:0] agree;
    logic [2:0] rise;
    cfg_word_t  shift_r;

    // Three-stage synchronisers
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            sync1_r <= 3'h0;
            sync2_r <= 3'h0;
            sync3_r <= 3'h0;
        end
        else
        begin
            sync1_r <= {load_strobe, serial_data_pin, serial_clock_pin};
            sync2_r <= sync1_r;
            sync3_r <= sync2_r;
        end
    end

    assign agree = ~(sync2_r ^ sync3_r);
    assign rise  = agree & sync3_r & ~filt_r;

    // Accepted pin levels
    always_ff @(posedge clk)
    begin
        if (reset)
            filt_r <= 3'h0;
        else
            filt_r <= (agree & sync3_r) | (~agree & filt_r);
    end

    // Shift register, MSB first
    always_ff @(posedge clk)
    begin
        if (reset)
            shift_r <= 32'h0;
        else if (rise[0])
            shift_r <= {shift_r[30:0], filt_r[1]};
    end

    // Latch on strobe rising edge
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            out.word  <= 32'h0;
            out.valid <= 1'b0;
        end
        else
        begin
            out.valid <= rise[2];
            if (rise[2])
                out.word <= shift_r;
        end
    end

endmodule : serial_word_in

// ---- sigma_delta2.sv ----
`timescale 1ns/1ps
`include "rx_cfg_consts.svh"
module sigma_delta2
    import rx_cfg_pkg::*;
(
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        reset,
    // Control
    input  wire logic        tick,
    input  wire logic        enable,
    input  wire logic [15:0] din,
    // Bit stream
    output logic             bit_out
);

    logic signed [19:0] err1_r;
    logic signed [19:0] err2_r;
    logic signed [19:0] sum;
    logic signed [19:0] quant;

    assign sum   = 20'(signed'({{4{din[15]}}, din})) + (err1_r <<< 1) - err2_r;
    assign quant = sum[19] ? -signed'(`SD_FS) : signed'(`SD_FS);

    // Error feedback loop, one step per tick
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            err1_r  <= 20'h0;
            err2_r  <= 20'h0;
            bit_out <= 1'b0;
        end
        else if (!enable)
        begin
            err1_r  <= 20'h0;
            err2_r  <= 20'h0;
            bit_out <= 1'b0;
        end
        else if (tick)
        begin
            err1_r  <= sum - quant;
            err2_r  <= err1_r;
            bit_out <= ~sum[19];
        end
    end

endmodule : sigma_delta2

// ---- word_if.sv ----
`timescale 1ns/1ps
interface word_if;
    import rx_cfg_pkg::*;
    cfg_word_t word;
    logic      valid;
    modport src (output word, output valid);
    modport dst (input word, input valid);
endinterface : word_if
